// file: rtl/rxs_regs.svh
// Register offsets, field positions, reset values and timing counts.
// Assumes inclusion by bare name from the rtl files of this block.
`ifndef RXS_REGS_SVH
`define RXS_REGS_SVH

// Register byte addresses
`define RXS_CTRL_ADDR 4'h0
`define RXS_STAT_ADDR 4'h4

// Control field positions
`define RXS_CTRL_MODE_LSB 0
`define RXS_CTRL_MODE_MSB 1
`define RXS_CTRL_SPEED100 2
`define RXS_CTRL_FULLDUP 3
`define RXS_CTRL_HB_EN 4
`define RXS_CTRL_MCLK_DIS 5
`define RXS_CTRL_WIDTH 6
`define RXS_CTRL_RESET 6'h14

// Status field positions
`define RXS_STAT_CARRIER 0
`define RXS_STAT_COL 1
`define RXS_STAT_DV 2
`define RXS_STAT_FILL_LSB 4

// Heartbeat timing
`define RXS_CLK_PERIOD_NS 100
`define RXS_HB_TIME_NS 1000
`define RXS_HB_CYCLES ((`RXS_HB_TIME_NS + `RXS_CLK_PERIOD_NS - 1) / `RXS_CLK_PERIOD_NS)

`endif

// file: rtl/rxs_pkg.sv
// Types shared by the receive status block.
// Assumes the constants header is compiled alongside.
package rxs_pkg;

	typedef enum logic [1:0] {
		RXS_MODE_MII = 2'h0,
		RXS_MODE_RMII = 2'h1,
		RXS_MODE_SERIAL = 2'h2
	} rxs_mode_e;

	typedef enum logic [1:0] {
		RXS_ST_IDLE = 2'h0,
		RXS_ST_DATA = 2'h1
	} rxs_state_e;

endpackage : rxs_pkg

// file: rtl/rxs_buf_if.sv
// Valid/ready carrier between the receive block and its buffer.
// Assumes one clock domain on both sides.
`timescale 1ns/1ps
interface rxs_buf_if #(
	parameter int W = 4
);
	logic in_valid;
	logic in_ready;
	logic [W-1:0] in_data;
	logic out_valid;
	logic out_ready;
	logic [W-1:0] out_data;

	modport store (
		input in_valid,
		output in_ready,
		input in_data,
		output out_valid,
		input out_ready,
		output out_data
	);

	modport user (
		output in_valid,
		input in_ready,
		output in_data,
		input out_valid,
		output out_ready,
		input out_data
	);
endinterface : rxs_buf_if

// file: rtl/rxs_buf.sv
// Small buffer of received nibbles with valid/ready on both sides.
// Assumes the user side samples in_ready and out_valid on clk.
`timescale 1ns/1ps
module rxs_buf #(
	parameter int W = 4,
	parameter int DEPTH = 2
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Buffer ports
	rxs_buf_if.store bif,
	// Fill level
	output logic [$clog2(DEPTH+1)-1:0] fill
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH+1);

	logic [W-1:0] mem_ff [DEPTH];
	logic [PW-1:0] wr_ptr_ff;
	logic [PW-1:0] rd_ptr_ff;
	logic [CW-1:0] cnt_ff;
	logic [CW-1:0] nxt_cnt;
	logic in_ready_ff;
	logic push;
	logic pop;

	assign push = bif.in_valid && in_ready_ff;
	assign pop = bif.out_valid && bif.out_ready;
	assign bif.in_ready = in_ready_ff;
	assign bif.out_valid = (cnt_ff != '0);
	assign bif.out_data = mem_ff[rd_ptr_ff];
	assign fill = cnt_ff;

	always_comb begin
		nxt_cnt = cnt_ff;
		if (push && !pop) begin
			nxt_cnt = cnt_ff + CW'(1);
		end else if (pop && !push) begin
			nxt_cnt = cnt_ff - CW'(1);
		end
	end

	// Storage
	always_ff @(posedge clk) begin
		if (push) begin
			mem_ff[wr_ptr_ff] <= bif.in_data;
		end
	end

	// Pointers, count and ready
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			cnt_ff <= '0;
			in_ready_ff <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr_ff <= (wr_ptr_ff == PW'(DEPTH-1)) ? '0 : wr_ptr_ff + PW'(1);
			end
			if (pop) begin
				rd_ptr_ff <= (rd_ptr_ff == PW'(DEPTH-1)) ? '0 : rd_ptr_ff + PW'(1);
			end
			cnt_ff <= nxt_cnt;
			in_ready_ff <= (nxt_cnt < CW'(DEPTH));
		end
	end

endmodule : rxs_buf

// file: rtl/rxs_rx_status.sv
// Receive data, carrier, collision and MAC clock outputs of one port.
// Assumes clk is far faster than the link clocks, which are sampled as pins.
`timescale 1ns/1ps
`include "rxs_regs.svh"

// Notes on behaviour
// - RMII sends dibits timed by reference clock.
// - Serial mode sends bits framed by carrier.
// - Serial mode keeps upper data lines zero.
// - Carrier follows medium activity in MII; serial also holds it while bits are in flight.
// - RMII merges carrier and data valid.
// - Half duplex collision when transmit meets receive, except in RMII.
// - Ten-meg half duplex heartbeat about 1us, except in RMII.
// - Full duplex holds collision low always.
// - MII mode forwards reference clock to MAC.
// - RMII mode forwards 50 MHz clock to MAC.
// - MII sends nibbles on receive clock.
// - Data valid exactly while nibbles are valid.
module rxs_rx_status
	import rxs_pkg::*;
#(
	parameter int DW = 4,
	parameter int BUF_DEPTH = 2,
	parameter int HB_CYCLES = `RXS_HB_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Receive path from the line side
	input wire logic sym_valid,
	input wire logic [DW-1:0] sym_data,
	output logic sym_ready,
	input wire logic medium_active,
	input wire logic tx_active,
	// Link clocks from pins
	input wire logic rx_clk_in,
	input wire logic ref_clock_in,
	// MAC side outputs
	output logic [DW-1:0] rxd,
	output logic rx_dv,
	output logic port_a_carrier_out,
	output logic col,
	output logic mac_clock_out
);
	localparam int CW = $clog2(BUF_DEPTH+1);
	localparam int HW = $clog2(HB_CYCLES+1);

	// Control register fields
	logic [`RXS_CTRL_WIDTH-1:0] ctrl_ff;
	rxs_mode_e mode;
	logic speed100;
	logic full_dup;
	logic hb_en;
	logic mclk_dis;

	assign mode = rxs_mode_e'(ctrl_ff[`RXS_CTRL_MODE_MSB:`RXS_CTRL_MODE_LSB]);
	assign speed100 = ctrl_ff[`RXS_CTRL_SPEED100];
	assign full_dup = ctrl_ff[`RXS_CTRL_FULLDUP];
	assign hb_en = ctrl_ff[`RXS_CTRL_HB_EN];
	assign mclk_dis = ctrl_ff[`RXS_CTRL_MCLK_DIS];

	// Pin synchronisers for both link clocks
	logic [1:0] clk_pin;
	logic [1:0] s1_ff;
	logic [1:0] s2_ff;
	logic [1:0] s3_ff;
	logic [1:0] lvl_ff;
	logic [1:0] rise;

	assign clk_pin = {ref_clock_in, rx_clk_in};

	for (genvar i = 0; i < 2; i++) begin : g_sync
		always_ff @(posedge clk or negedge resetn) begin
			if (!resetn) begin
				s1_ff[i] <= 1'b0;
				s2_ff[i] <= 1'b0;
				s3_ff[i] <= 1'b0;
				lvl_ff[i] <= 1'b0;
			end else begin
				s1_ff[i] <= clk_pin[i];
				s2_ff[i] <= s1_ff[i];
				s3_ff[i] <= s2_ff[i];
				if (s2_ff[i] == s3_ff[i]) begin
					lvl_ff[i] <= s2_ff[i];
				end
			end
		end
		assign rise[i] = (s2_ff[i] == s3_ff[i]) && s2_ff[i] && !lvl_ff[i];
	end

	// Receive clock tick: reference clock in RMII, recovered clock otherwise
	logic tick;
	assign tick = (mode == RXS_MODE_RMII) ? rise[1] : rise[0];

	// Symbol slice for the current mode and phase
	function automatic logic [DW-1:0] slice_of(input rxs_mode_e m, input logic [DW-1:0] w,
		input logic [1:0] idx);
		logic [DW-1:0] r;
		r = '0;
		case (m)
			RXS_MODE_MII: begin
				r = w;
			end
			RXS_MODE_RMII: begin
				r[1:0] = w[{idx[0], 1'b0} +: 2];
			end
			RXS_MODE_SERIAL: begin
				r[0] = w[idx];
			end
			default: begin
				r = '0;
			end
		endcase
		return r;
	endfunction : slice_of

	function automatic logic [1:0] last_phase(input rxs_mode_e m);
		logic [1:0] r;
		case (m)
			RXS_MODE_RMII: r = 2'h1;
			RXS_MODE_SERIAL: r = 2'h3;
			default: r = 2'h0;
		endcase
		return r;
	endfunction : last_phase

	// Word boundary: nothing in flight or last unit on the lines
	function automatic logic word_done(input rxs_state_e s, input logic [1:0] ph, input rxs_mode_e m);
		logic r;
		r = (s == RXS_ST_IDLE) || (ph == last_phase(m));
		return r;
	endfunction : word_done

	// Collision output held low
	function automatic logic col_quiet(input rxs_mode_e m, input logic fd);
		logic r;
		r = fd || (m == RXS_MODE_RMII);
		return r;
	endfunction : col_quiet

	// Buffer in the data path
	rxs_buf_if #(.W(DW)) bif ();
	logic [CW-1:0] fill;

	rxs_buf #(
		.W(DW),
		.DEPTH(BUF_DEPTH)
	) u_buf (
		.clk(clk),
		.resetn(resetn),
		.bif(bif),
		.fill(fill)
	);

	assign bif.in_valid = sym_valid;
	assign bif.in_data = sym_data;

	// Output shifter
	rxs_state_e st_ff;
	logic [DW-1:0] word_ff;
	logic [1:0] phase_ff;
	logic [DW-1:0] rxd_ff;
	logic rx_dv_ff;
	logic take;

	assign take = tick && bif.out_valid && word_done(st_ff, phase_ff, mode);
	assign bif.out_ready = take;

	// Shifter state
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_ff <= RXS_ST_IDLE;
		end else if (tick) begin
			if (take) begin
				st_ff <= RXS_ST_DATA;
			end else if (word_done(st_ff, phase_ff, mode)) begin
				st_ff <= RXS_ST_IDLE;
			end
		end
	end

	// Unit index within the word
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			phase_ff <= 2'h0;
		end else if (tick) begin
			if (take) begin
				phase_ff <= 2'h0;
			end else if (!word_done(st_ff, phase_ff, mode)) begin
				phase_ff <= phase_ff + 2'h1;
			end
		end
	end

	// Word being sent
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			word_ff <= '0;
		end else if (take) begin
			word_ff <= bif.out_data;
		end
	end

	// Receive data lines
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rxd_ff <= '0;
		end else if (tick) begin
			if (take) begin
				rxd_ff <= slice_of(mode, bif.out_data, 2'h0);
			end else if (word_done(st_ff, phase_ff, mode)) begin
				rxd_ff <= '0;
			end else begin
				rxd_ff <= slice_of(mode, word_ff, phase_ff + 2'h1);
			end
		end
	end

	// Data valid beside the lines
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rx_dv_ff <= 1'b0;
		end else if (tick) begin
			if (take) begin
				rx_dv_ff <= (mode != RXS_MODE_SERIAL);
			end else if (word_done(st_ff, phase_ff, mode)) begin
				rx_dv_ff <= 1'b0;
			end
		end
	end

	// Carrier and merged carrier/data valid
	logic carrier_ff;
	logic nxt_carrier;

	always_comb begin
		case (mode)
			RXS_MODE_RMII: nxt_carrier = medium_active || take ||
				!word_done(st_ff, phase_ff, mode);
			RXS_MODE_SERIAL: nxt_carrier = medium_active || take ||
				!word_done(st_ff, phase_ff, mode);
			default: nxt_carrier = medium_active;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			carrier_ff <= 1'b0;
		end else if (tick) begin
			carrier_ff <= nxt_carrier;
		end
	end

	// Collision and heartbeat
	logic tx_d_ff;
	logic [HW-1:0] hb_cnt_ff;
	logic col_ff;
	logic clash;

	assign clash = tx_active && medium_active;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tx_d_ff <= 1'b0;
			hb_cnt_ff <= '0;
		end else begin
			tx_d_ff <= tx_active;
			if (col_quiet(mode, full_dup) || speed100 || !hb_en) begin
				hb_cnt_ff <= '0;
			end else if (tx_d_ff && !tx_active) begin
				hb_cnt_ff <= HW'(HB_CYCLES);
			end else if (hb_cnt_ff != '0) begin
				hb_cnt_ff <= hb_cnt_ff - HW'(1);
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			col_ff <= 1'b0;
		end else if (col_quiet(mode, full_dup)) begin
			col_ff <= 1'b0;
		end else if (mode == RXS_MODE_SERIAL) begin
			col_ff <= clash || (hb_cnt_ff != '0);
		end else begin
			col_ff <= clash || (hb_cnt_ff != '0);
		end
	end

	// Clock forwarded to the MAC
	logic mclk_ff;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mclk_ff <= 1'b0;
		end else begin
			mclk_ff <= lvl_ff[1] && !mclk_dis;
		end
	end

	// Register port
	logic [31:0] rdata_ff;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_ff <= `RXS_CTRL_RESET;
		end else if (reg_wr && reg_addr == `RXS_CTRL_ADDR) begin
			ctrl_ff <= reg_wdata[`RXS_CTRL_WIDTH-1:0];
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata_ff <= 32'h0;
		end else if (reg_rd) begin
			rdata_ff <= 32'h0;
			case (reg_addr)
				`RXS_CTRL_ADDR: begin
					rdata_ff[`RXS_CTRL_WIDTH-1:0] <= ctrl_ff;
				end
				`RXS_STAT_ADDR: begin
					rdata_ff[`RXS_STAT_CARRIER] <= carrier_ff;
					rdata_ff[`RXS_STAT_COL] <= col_ff;
					rdata_ff[`RXS_STAT_DV] <= rx_dv_ff;
					rdata_ff[`RXS_STAT_FILL_LSB +: CW] <= fill;
				end
				default: begin
					rdata_ff <= 32'h0;
				end
			endcase
		end else begin
			rdata_ff <= 32'h0;
		end
	end

	// Output wiring
	assign sym_ready = bif.in_ready;
	assign rxd = rxd_ff;
	assign rx_dv = rx_dv_ff;
	assign port_a_carrier_out = carrier_ff;
	assign col = col_ff;
	assign mac_clock_out = mclk_ff;
	assign reg_rdata = rdata_ff;

endmodule : rxs_rx_status

// file: dv/rxs_chk_assertions.sv
// Port checker for the receive status block.
// Assumes a bind onto rxs_rx_status; CTRL is shadowed from port writes.
`timescale 1ns/1ps
`include "rxs_regs.svh"
module rxs_chk
	import rxs_pkg::*;
#(
	parameter int DW = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Inputs
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic medium_active,
	input wire logic tx_active,
	input wire logic ref_clock_in,
	// Outputs
	input wire logic [DW-1:0] rxd,
	input wire logic rx_dv,
	input wire logic port_a_carrier_out,
	input wire logic col,
	input wire logic mac_clock_out
);
	logic [5:0] ctrl_ff;
	logic mii, rmii, ser, fd, hb, hit, mdis;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_ff <= `RXS_CTRL_RESET;
		end else if (reg_wr && reg_addr == `RXS_CTRL_ADDR) begin
			ctrl_ff <= reg_wdata[5:0];
		end
	end
	assign mii = ctrl_ff[1:0] == RXS_MODE_MII;
	assign rmii = ctrl_ff[1:0] == RXS_MODE_RMII;
	assign ser = ctrl_ff[1:0] == RXS_MODE_SERIAL;
	assign fd = ctrl_ff[3];
	assign mdis = ctrl_ff[5];
	assign hb = !ctrl_ff[2] && !fd && ctrl_ff[4] && !rmii;
	assign hit = !fd && !rmii && tx_active && medium_active;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	a_rmii_dibit: assert property (rmii && $past(rmii) |-> rxd[3:2] == 2'h0)
		else $error("rmii upper lines set");
	a_ser_upper: assert property (ser && $past(ser) |-> rxd[3:1] == 3'h0 && !rx_dv)
		else $error("serial upper lines set");
	a_ser_frame: assert property (ser && rxd[0] |-> port_a_carrier_out)
		else $error("serial bit outside carrier");
	a_mii_carrier: assert property (mii && $past(mii) && $changed(port_a_carrier_out) |->
		port_a_carrier_out == $past(medium_active))
		else $error("carrier not following medium");
	a_rmii_crs: assert property (rmii && $past(rmii) && (rx_dv ||
		($changed(port_a_carrier_out) && $past(medium_active))) |-> port_a_carrier_out)
		else $error("merged carrier low");
	a_col_half: assert property ($past(hit) |-> col)
		else $error("collision missed");
	a_col_full: assert property (fd && $past(fd) |-> !col)
		else $error("collision in full duplex");
	a_heart_beat: assert property ($fell(tx_active) && hb && !medium_active |-> ##[1:3] col[*8] ##3 !col)
		else $error("heartbeat length wrong");
	a_mclk_off: assert property (mdis && $past(mdis) |-> !mac_clock_out)
		else $error("mac clock not off");
	a_mclk_copy: assert property (!mdis && $changed(mac_clock_out) |->
		mac_clock_out == $past(ref_clock_in, 3))
		else $error("mac clock not a copy");
	c_heart: cover property ($fell(tx_active) && hb);
	c_rmii: cover property (rmii && rx_dv);
	c_ser: cover property (ser && rxd[0]);
endmodule : rxs_chk

bind rxs_rx_status rxs_chk #(.DW(DW)) u_chk (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .medium_active(medium_active), .tx_active(tx_active),
	.ref_clock_in(ref_clock_in), .rxd(rxd), .rx_dv(rx_dv), .port_a_carrier_out(port_a_carrier_out),
	.col(col), .mac_clock_out(mac_clock_out));

// file: dv/rxs_mac_model.sv
// MAC side model: free running link clocks, collision from carrier.
// Assumes a 100 ns bench clock; phases unrelated to it.
`timescale 1ns/1ps
module rxs_mac_model (
	// From the device
	input wire logic crs_dv,
	input wire logic tx_en,
	// Clocks to the device
	output logic rx_clk_in,
	output logic ref_clock_in,
	// Collision seen by the MAC
	output logic mac_col
);
	initial begin
		rx_clk_in = 1'b0;
		#253;
		forever #400 rx_clk_in = !rx_clk_in;
	end
	initial begin
		ref_clock_in = 1'b0;
		#137;
		forever #400 ref_clock_in = !ref_clock_in;
	end
	assign mac_col = crs_dv && tx_en;
endmodule : rxs_mac_model

// file: dv/test_phy_mac_rx_status_and_clocking.sv
// Bench for the receive status block.
// Assumes header, package, design, checker and MAC model compiled first.
`timescale 1ns/1ps
`include "rxs_regs.svh"
module test_phy_mac_rx_status_and_clocking;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic sym_valid = 1'b0;
	logic [3:0] sym_data = 4'h0;
	logic medium_active = 1'b0;
	logic tx_active = 1'b0;
	logic rd_q = 1'b0;
	logic stalled = 1'b0;
	logic mclk_seen = 1'b0;
	logic [4:0] last = 5'h0;
	logic [31:0] reg_rdata;
	logic [3:0] rxd;
	logic sym_ready, rx_clk_in, ref_clock_in, rx_dv, crs, col, mclk, mac_col;
	logic [31:0] rq[$];
	logic [3:0] dq[$];
	int failures = 0;
	int tests_run = 0;
	int mode = 0;
	int seed;

	always #50 clk = ~clk;

	rxs_rx_status #(.HB_CYCLES(10)) dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.sym_valid(sym_valid), .sym_data(sym_data), .sym_ready(sym_ready), .medium_active(medium_active),
		.tx_active(tx_active), .rx_clk_in(rx_clk_in), .ref_clock_in(ref_clock_in), .rxd(rxd),
		.rx_dv(rx_dv), .port_a_carrier_out(crs), .col(col), .mac_clock_out(mclk));
	rxs_mac_model u_mac (.crs_dv(crs), .tx_en(tx_active), .rx_clk_in(rx_clk_in),
		.ref_clock_in(ref_clock_in), .mac_col(mac_col));

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		tests_run++;
		if (s !== e) begin
			failures++;
			$display("[FAIL] %s exp %h got %h", n, e, s);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		rq.push_back(e);
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
	endtask : rd

	task automatic coll(input logic [31:0] c, input logic [31:0] s, input logic h);
		wr(`RXS_CTRL_ADDR, c);
		medium_active <= 1'b1;
		tx_active <= 1'b1;
		repeat (12) @(posedge clk);
		chk("mac_col", 1, mac_col);
		rd(`RXS_STAT_ADDR, s);
		medium_active <= 1'b0;
		tx_active <= 1'b0;
		repeat (3) @(posedge clk);
		chk("heartbeat", 32'(h), col);
		repeat (13) @(posedge clk);
	endtask : coll

	task automatic burst(input int m, input int n);
		logic [3:0] v;
		logic [3:0] p;
		mode = m;
		p = 4'h0;
		medium_active <= 1'b1;
		for (int i = 0; i < n; i++) begin
			case (m)
				0: v = p ^ 4'($urandom_range(1, 15));
				1: begin
					v[1:0] = p[3:2] ^ 2'($urandom_range(1, 3));
					v[3:2] = v[1:0] ^ 2'($urandom_range(1, 3));
				end
				default: v = 4'h5;
			endcase
			for (int b = 0; b < 4; b += (m == 0) ? 4 : (m == 1) ? 2 : 1)
				dq.push_back(m == 0 ? v : m == 1 ? {2'h0, v[b +: 2]} : {3'h0, v[b]});
			sym_valid <= 1'b1;
			sym_data <= v;
			p = v;
			do @(posedge clk); while (sym_ready !== 1'b1);
		end
		sym_valid <= 1'b0;
		for (int i = 0; i < 600 && dq.size() > 0; i++) @(posedge clk);
		chk("drain", 0, dq.size());
		medium_active <= 1'b0;
		repeat (20) @(posedge clk);
	endtask : burst

	task automatic wrap_up();
		$display("Checks %0d, failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : wrap_up

	// Read results and buffer stall watch
	always @(posedge clk) begin
		rd_q <= reg_rd;
		if (rd_q) chk("rdata", rq.pop_front(), reg_rdata);
		if (sym_valid && !sym_ready) stalled <= 1'b1;
		if (mclk === 1'b1) mclk_seen <= 1'b1;
	end

	// Each new unit on the receive lines
	always @(negedge clk) begin
		if ((rx_dv || (mode == 2 && crs)) && {rxd, rx_dv} !== last) chk("rxd", 32'(dq.pop_front()), 32'(rxd));
		last <= {rxd, rx_dv};
	end

	initial begin
		#2000000;
		failures++;
		wrap_up();
	end

	initial begin
		seed = $urandom(62);
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		rd(`RXS_CTRL_ADDR, 32'(`RXS_CTRL_RESET));
		rd(4'h8, 32'h0);
		wr(`RXS_STAT_ADDR, 32'hFFFFFFFF);
		rd(`RXS_STAT_ADDR, 32'h0);
		coll(32'h10, 32'h3, 1'b1);
		coll(32'h18, 32'h1, 1'b0);
		coll(32'h12, 32'h3, 1'b1);
		coll(32'h14, 32'h3, 1'b0);
		coll(32'h11, 32'h1, 1'b0);
		for (int m = 0; m < 3; m++) begin
			wr(`RXS_CTRL_ADDR, 32'h10 | m);
			rd(`RXS_CTRL_ADDR, 32'h10 | m);
			burst(m, 6);
		end
		chk("stall", 1, stalled);
		chk("mclk_run", 1, mclk_seen);
		wr(`RXS_CTRL_ADDR, 32'h30);
		repeat (20) @(posedge clk);
		chk("mclk_off", 0, mclk);
		wrap_up();
	end
endmodule : test_phy_mac_rx_status_and_clocking
